/* rtl/switch_global_control_pkg.sv */
package switch_global_control_pkg;
  // ----------------------------------------------------------------
  // register map: two byte-wide registers, at bus addresses 3 and 4; other addresses read zero
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] IDX_CTRL_A = 8'h03;
  localparam logic [ADDR_W-1:0] IDX_CTRL_B = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A = IDX_CTRL_A;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B = IDX_CTRL_B;

  // ----------------------------------------------------------------
  // field positions, first control register
  // ----------------------------------------------------------------
  localparam int A_PASS_ALL = 7;
  localparam int A_REPEATER = 6;
  localparam int A_TX_FC = 5;
  localparam int A_RX_FC = 4;
  localparam int A_LEN_CHECK = 3;
  localparam int A_AGING = 2;
  localparam int A_FAST_AGE = 1;
  localparam int A_AGGR_BACKOFF = 0;

  // ----------------------------------------------------------------
  // field positions, second control register
  // ----------------------------------------------------------------
  localparam int B_VLAN_STRICT = 7;
  localparam int B_MCAST_STORM_OFF = 6;
  localparam int B_BP_CARRIER = 5;
  localparam int B_FAIR = 4;
  localparam int B_NO_EXCESS_DROP = 3;
  localparam int B_HUGE = 2;
  localparam int B_LEGAL_SIZE = 1;
  localparam int B_PRIO_RESERVE = 0;

  // ----------------------------------------------------------------
  // reset values; strap bits reset to zero and are loaded after release
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_A_RESET = 8'h34;
  localparam logic [DATA_W-1:0] CTRL_B_RESET = 8'hf1;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // ----------------------------------------------------------------
  // frame limits
  // ----------------------------------------------------------------
  localparam logic [10:0] LEN_HUGE_MAX = 11'd1916;
  localparam logic [10:0] LEN_DEFAULT_MAX = 11'd1536;
  localparam logic [10:0] LEN_LEGAL_TAGGED = 11'd1522;
  localparam logic [10:0] LEN_LEGAL_UNTAGGED = 11'd1518;
  localparam logic [15:0] LEN_TYPE_LIMIT = 16'd1500;
  localparam logic [10:0] HDR_UNTAGGED = 11'd18;
  localparam logic [10:0] HDR_TAGGED = 11'd22;
  localparam logic [10:0] MIN_PAYLOAD = 11'd46;
  localparam int BCAST_MCAST_BIT = 40;
  localparam logic [4:0] EXCESS_COLLISIONS = 5'd16;
  localparam logic [5:0] PRIO_RESERVED_BUFFERS = 6'd48;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int FAST_AGE_US = 800;
  localparam int NORMAL_AGE_S = 200;
  localparam int NORMAL_AGE_US = NORMAL_AGE_S * 1000000;
  localparam int AGE_CNT_W = 28;
endpackage : switch_global_control_pkg

/* rtl/switch_global_control_regs.sv */
`timescale 1ns/1ps
module switch_global_control_regs
  import switch_global_control_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int FAST_AGE_TICKS = FAST_AGE_US,
  parameter int NORMAL_AGE_TICKS = NORMAL_AGE_US
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  input wire logic switch_port_mode_strap,
  input wire logic switch_port_rx_bit0_strap,
  input wire logic sniffer_active,
  input wire logic link_loss_age,
  input wire logic frame_valid,
  input wire logic [10:0] frame_len,
  input wire logic frame_tagged,
  input wire logic frame_errored,
  input wire logic [15:0] frame_len_type,
  input wire logic [47:0] frame_da,
  input wire logic frame_crosses_vlan,
  input wire logic frame_known_unicast,
  input wire logic [4:0] collision_count,
  input wire logic shared_dest_contention,
  output logic verdict_valid,
  output logic verdict_accept,
  output logic verdict_drop_error,
  output logic verdict_drop_size,
  output logic verdict_drop_length,
  output logic verdict_drop_vlan,
  output logic verdict_storm_regulated,
  output logic excess_collision_drop,
  output logic drop_non_fc_source,
  output logic pause_fc_source,
  output logic repeater_mode,
  output logic tx_flow_ctrl_en,
  output logic rx_flow_ctrl_en,
  output logic aggressive_backoff,
  output logic carrier_sense_backpressure,
  output logic port_mirror_allowed,
  output logic [5:0] prio_reserved_buffers,
  output logic age_pulse,
  output logic fast_age_active
);
  // ----------------------------------------------------------------
  // strap synchronisers and load after reset release
  // ----------------------------------------------------------------
  logic [1:0] strap_meta_q;
  logic [1:0] strap_sync_q;
  logic [1:0] strap_cnt_q;
  logic strap_done_q;
  wire strap_load = !strap_done_q && (strap_cnt_q == STRAP_WAIT);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_meta_q <= 2'h0;
      strap_sync_q <= 2'h0;
    end else begin
      strap_meta_q <= {switch_port_rx_bit0_strap, switch_port_mode_strap};
      strap_sync_q <= strap_meta_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      strap_done_q <= strap_load;
    end
  end

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_a_q;
  logic [DATA_W-1:0] ctrl_b_q;
  logic [DATA_W-1:0] ctrl_a_d;
  logic [DATA_W-1:0] ctrl_b_d;
  logic [DATA_W-1:0] rd_data_q;
  wire hit_a = (addr == ADDR_CTRL_A);
  wire hit_b = (addr == ADDR_CTRL_B);
  wire [DATA_W-1:0] rd_mux = hit_a ? ctrl_a_q : (hit_b ? ctrl_b_q : 8'h00);

  always_comb begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    if (wr_en && hit_a) begin
      ctrl_a_d = wr_data;
    end
    if (wr_en && hit_b) begin
      ctrl_b_d = wr_data;
    end
    if (strap_load) begin
      ctrl_a_d[A_AGGR_BACKOFF] = strap_sync_q[0];
      ctrl_b_d[B_NO_EXCESS_DROP] = strap_sync_q[0];
      ctrl_b_d[B_LEGAL_SIZE] = strap_sync_q[1];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a_q <= CTRL_A_RESET;
      ctrl_b_q <= CTRL_B_RESET;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_en ? rd_mux : 8'h00;
    end
  end
  assign rd_data = rd_data_q;

  // ----------------------------------------------------------------
  // static control outputs
  // ----------------------------------------------------------------
  assign repeater_mode = ctrl_a_q[A_REPEATER];
  assign tx_flow_ctrl_en = ctrl_a_q[A_TX_FC];
  assign rx_flow_ctrl_en = ctrl_a_q[A_RX_FC];
  assign aggressive_backoff = ctrl_a_q[A_AGGR_BACKOFF];
  assign carrier_sense_backpressure = ctrl_b_q[B_BP_CARRIER];
  assign port_mirror_allowed = ctrl_b_q[B_VLAN_STRICT];
  assign prio_reserved_buffers = ctrl_b_q[B_PRIO_RESERVE] ? PRIO_RESERVED_BUFFERS : 6'h00;

  // ----------------------------------------------------------------
  // frame admission decode
  // ----------------------------------------------------------------
  wire [10:0] hdr_len = frame_tagged ? HDR_TAGGED : HDR_UNTAGGED;
  wire [10:0] payload_len = (frame_len > hdr_len) ? (frame_len - hdr_len) : 11'h000;
  wire [10:0] legal_max = frame_tagged ? LEN_LEGAL_TAGGED : LEN_LEGAL_UNTAGGED;
  wire [10:0] size_max = ctrl_b_q[B_HUGE] ? LEN_HUGE_MAX :
                         (ctrl_b_q[B_LEGAL_SIZE] ? legal_max : LEN_DEFAULT_MAX);
  wire pass_bad = ctrl_a_q[A_PASS_ALL] && sniffer_active;
  wire err_drop = frame_errored && !pass_bad;
  wire size_drop = frame_len > size_max;
  wire padded = (payload_len == MIN_PAYLOAD) && (frame_len_type < 16'(MIN_PAYLOAD));
  wire len_mismatch = (frame_len_type != 16'(payload_len)) && !padded;
  wire len_drop = ctrl_a_q[A_LEN_CHECK] && (frame_len_type < LEN_TYPE_LIMIT) && len_mismatch;
  wire vlan_drop = frame_crosses_vlan && (ctrl_b_q[B_VLAN_STRICT] || !frame_known_unicast);
  wire da_bcast = &frame_da;
  wire storm_hit = da_bcast || (!ctrl_b_q[B_MCAST_STORM_OFF] && frame_da[BCAST_MCAST_BIT]);

  logic verdict_valid_q;
  logic verdict_accept_q;
  logic drop_error_q;
  logic drop_size_q;
  logic drop_length_q;
  logic drop_vlan_q;
  logic storm_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      verdict_valid_q <= 1'b0;
      verdict_accept_q <= 1'b0;
      drop_error_q <= 1'b0;
      drop_size_q <= 1'b0;
      drop_length_q <= 1'b0;
      drop_vlan_q <= 1'b0;
      storm_q <= 1'b0;
    end else begin
      verdict_valid_q <= frame_valid;
      verdict_accept_q <= frame_valid && !(err_drop || size_drop || len_drop || vlan_drop);
      drop_error_q <= frame_valid && err_drop;
      drop_size_q <= frame_valid && size_drop;
      drop_length_q <= frame_valid && len_drop;
      drop_vlan_q <= frame_valid && vlan_drop;
      storm_q <= frame_valid && storm_hit;
    end
  end

  assign verdict_valid = verdict_valid_q;
  assign verdict_accept = verdict_accept_q;
  assign verdict_drop_error = drop_error_q;
  assign verdict_drop_size = drop_size_q;
  assign verdict_drop_length = drop_length_q;
  assign verdict_drop_vlan = drop_vlan_q;
  assign verdict_storm_regulated = storm_q;

  // ----------------------------------------------------------------
  // collision and contention decisions
  // ----------------------------------------------------------------
  logic excess_drop_q;
  logic drop_non_fc_q;
  logic pause_fc_q;
  wire excess_hit = (collision_count >= EXCESS_COLLISIONS) && !ctrl_b_q[B_NO_EXCESS_DROP];
  wire fair_mode = ctrl_b_q[B_FAIR];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      excess_drop_q <= 1'b0;
      drop_non_fc_q <= 1'b0;
      pause_fc_q <= 1'b0;
    end else begin
      excess_drop_q <= excess_hit;
      drop_non_fc_q <= shared_dest_contention && fair_mode;
      pause_fc_q <= shared_dest_contention && !fair_mode;
    end
  end
  assign excess_collision_drop = excess_drop_q;
  assign drop_non_fc_source = drop_non_fc_q;
  assign pause_fc_source = pause_fc_q;

  // ----------------------------------------------------------------
  // aging timer: microsecond tick, normal or one fast cycle
  // ----------------------------------------------------------------
  localparam logic [7:0] TICK_LAST = 8'(TICK_LEN - 1);
  localparam logic [AGE_CNT_W-1:0] FAST_LAST = AGE_CNT_W'(FAST_AGE_TICKS - 1);
  localparam logic [AGE_CNT_W-1:0] NORMAL_LAST = AGE_CNT_W'(NORMAL_AGE_TICKS - 1);
  logic [7:0] tick_cnt_q;
  logic us_tick_q;
  logic [AGE_CNT_W-1:0] age_cnt_q;
  logic fast_bit_prev_q;
  logic fast_pending_q;
  logic age_pulse_q;
  wire aging_en = ctrl_a_q[A_AGING];
  wire fast_req = (ctrl_a_q[A_FAST_AGE] && !fast_bit_prev_q) || link_loss_age;
  wire [AGE_CNT_W-1:0] age_last = fast_pending_q ? FAST_LAST : NORMAL_LAST;
  wire age_done = aging_en && us_tick_q && !fast_req && (age_cnt_q >= age_last);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= 8'h00;
      us_tick_q <= 1'b0;
    end else begin
      us_tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 8'h00 : tick_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age_cnt_q <= '0;
    end else if (!aging_en || fast_req || age_done) begin
      age_cnt_q <= '0;
    end else if (us_tick_q) begin
      age_cnt_q <= age_cnt_q + AGE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_bit_prev_q <= 1'b0;
      fast_pending_q <= 1'b0;
      age_pulse_q <= 1'b0;
    end else begin
      fast_bit_prev_q <= ctrl_a_q[A_FAST_AGE];
      fast_pending_q <= fast_req || (fast_pending_q && !age_done);
      age_pulse_q <= age_done;
    end
  end
  assign age_pulse = age_pulse_q;
  assign fast_age_active = fast_pending_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_read_data_slot: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside its slot");

  a_write_ctrl_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_en && hit_a && !strap_load |=> ctrl_a_q == $past(wr_data))
    else $error("control a write lost");

  a_strap_load: assert property (@(posedge clk) disable iff (!arst_n)
    strap_load && !wr_en |=> {ctrl_b_q[B_LEGAL_SIZE], ctrl_a_q[A_AGGR_BACKOFF]} == $past(strap_sync_q)
      && ctrl_b_q[B_NO_EXCESS_DROP] == ctrl_a_q[A_AGGR_BACKOFF])
    else $error("strap value not captured");

  a_bad_frame_pass: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && frame_errored && !(ctrl_a_q[A_PASS_ALL] && sniffer_active) |=> !verdict_accept && verdict_drop_error)
    else $error("errored frame forwarded");

  a_huge_limit: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && ctrl_b_q[B_HUGE] |=> verdict_drop_size == ($past(frame_len) > 11'd1916))
    else $error("huge size limit wrong");

  a_legal_limit: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && !ctrl_b_q[B_HUGE] && ctrl_b_q[B_LEGAL_SIZE] && !frame_tagged
      |=> verdict_drop_size == ($past(frame_len) > 11'd1518))
    else $error("legal size limit wrong");

  a_storm_scope: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && ctrl_b_q[B_MCAST_STORM_OFF] && !(&frame_da) |=> !verdict_storm_regulated)
    else $error("multicast regulated while excluded");

  a_excess_coll: assert property (@(posedge clk) disable iff (!arst_n)
    collision_count >= 5'd16 && !ctrl_b_q[B_NO_EXCESS_DROP] |=> excess_collision_drop)
    else $error("excess collision frame kept");

  a_fair_choice: assert property (@(posedge clk) disable iff (!arst_n)
    shared_dest_contention |=> drop_non_fc_source == $past(fair_mode) && pause_fc_source == !$past(fair_mode))
    else $error("contention resolution wrong");

  a_aging_off: assert property (@(posedge clk) disable iff (!arst_n)
    !aging_en && !$past(aging_en) |-> !age_pulse)
    else $error("age pulse while aging disabled");

  a_fast_once: assert property (@(posedge clk) disable iff (!arst_n)
    age_pulse && $past(fast_pending_q) && !$past(fast_req) |-> !fast_pending_q)
    else $error("fast aging did not return to normal");

  a_vlan_strict: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && frame_crosses_vlan && ctrl_b_q[B_VLAN_STRICT] |=> verdict_drop_vlan && !verdict_accept)
    else $error("frame crossed vlan boundary");

  a_unicast_cross: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && frame_crosses_vlan && !ctrl_b_q[B_VLAN_STRICT] |=> verdict_drop_vlan == !$past(frame_known_unicast))
    else $error("unicast vlan crossing wrong");

  a_pass_all_sniff: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && ctrl_a_q[A_PASS_ALL] && sniffer_active |=> !verdict_drop_error)
    else $error("errored frame dropped under pass-all");

  a_len_check_off: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && (!ctrl_a_q[A_LEN_CHECK] || frame_len_type >= LEN_TYPE_LIMIT) |=> !verdict_drop_length)
    else $error("length field drop while not checked");

  a_default_limit: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && !ctrl_b_q[B_HUGE] && !ctrl_b_q[B_LEGAL_SIZE]
      |=> verdict_drop_size == ($past(frame_len) > LEN_DEFAULT_MAX))
    else $error("default size limit wrong");

  a_legal_tagged: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && !ctrl_b_q[B_HUGE] && ctrl_b_q[B_LEGAL_SIZE] && frame_tagged
      |=> verdict_drop_size == ($past(frame_len) > LEN_LEGAL_TAGGED))
    else $error("tagged size limit wrong");

  a_storm_bcast: assert property (@(posedge clk) disable iff (!arst_n)
    frame_valid && (&frame_da) |=> verdict_storm_regulated)
    else $error("broadcast frame not regulated");

  a_verdict_slot: assert property (@(posedge clk) disable iff (!arst_n)
    !frame_valid |=> !(verdict_valid || verdict_accept || verdict_drop_error || verdict_drop_size
      || verdict_drop_length || verdict_drop_vlan || verdict_storm_regulated))
    else $error("verdict outside its slot");

  a_excess_keep: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_b_q[B_NO_EXCESS_DROP] |=> !excess_collision_drop)
    else $error("excess collision frame dropped while kept");

  a_fast_start: assert property (@(posedge clk) disable iff (!arst_n)
    fast_req |=> fast_age_active)
    else $error("fast aging request lost");
endmodule : switch_global_control_regs

/* sim/switch_global_control_regs_test.sv */
`timescale 1ns/1ps
module switch_global_control_regs_test
  import switch_global_control_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic [DATA_W-1:0] rd_data;
  logic wr_en = 1'b0, rd_en = 1'b0, switch_port_mode_strap = 1'b0, switch_port_rx_bit0_strap = 1'b0;
  logic sniffer_active = 1'b0, link_loss_age = 1'b0, frame_valid = 1'b0, frame_tagged = 1'b0;
  logic frame_errored = 1'b0, frame_crosses_vlan = 1'b0, frame_known_unicast = 1'b0;
  logic shared_dest_contention = 1'b0;
  logic [10:0] frame_len = '0;
  logic [15:0] frame_len_type = '0;
  logic [47:0] frame_da = '0;
  logic [4:0] collision_count = '0;
  logic v_valid, v_accept, v_err, v_size, v_len, v_vlan, v_storm, excess_collision_drop;
  logic drop_non_fc_source, pause_fc_source, repeater_mode, tx_flow_ctrl_en, rx_flow_ctrl_en;
  logic aggressive_backoff, carrier_sense_backpressure, port_mirror_allowed, age_pulse, fast_age_active;
  logic [5:0] prio_reserved_buffers;
  logic [7:0] sa, sb, v;
  logic [10:0] corner [0:9] = '{11'h5ee, 11'h5ef, 11'h5f2, 11'h5f3, 11'h600, 11'h601, 11'h77c, 11'h77d,
    11'h040, 11'h7ff};
  int err_total = 0;
  int compares = 0;
  int n;

  always #2 clk = ~clk;

  switch_global_control_regs #(.TICK_LEN(4), .FAST_AGE_TICKS(3), .NORMAL_AGE_TICKS(10)) u_switch_global_control_regs (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .switch_port_mode_strap(switch_port_mode_strap),
    .switch_port_rx_bit0_strap(switch_port_rx_bit0_strap), .sniffer_active(sniffer_active),
    .link_loss_age(link_loss_age), .frame_valid(frame_valid), .frame_len(frame_len),
    .frame_tagged(frame_tagged), .frame_errored(frame_errored), .frame_len_type(frame_len_type),
    .frame_da(frame_da), .frame_crosses_vlan(frame_crosses_vlan), .frame_known_unicast(frame_known_unicast),
    .collision_count(collision_count), .shared_dest_contention(shared_dest_contention),
    .verdict_valid(v_valid), .verdict_accept(v_accept), .verdict_drop_error(v_err),
    .verdict_drop_size(v_size), .verdict_drop_length(v_len), .verdict_drop_vlan(v_vlan),
    .verdict_storm_regulated(v_storm), .excess_collision_drop(excess_collision_drop),
    .drop_non_fc_source(drop_non_fc_source), .pause_fc_source(pause_fc_source),
    .repeater_mode(repeater_mode), .tx_flow_ctrl_en(tx_flow_ctrl_en), .rx_flow_ctrl_en(rx_flow_ctrl_en),
    .aggressive_backoff(aggressive_backoff), .carrier_sense_backpressure(carrier_sense_backpressure),
    .port_mirror_allowed(port_mirror_allowed), .prio_reserved_buffers(prio_reserved_buffers),
    .age_pulse(age_pulse), .fast_age_active(fast_age_active));

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h0, exp}, {7'h0, got});
  endtask : chk1

  task automatic chkn(input string what, input int exp, input int got);
    compares++;
    if (got != exp) begin
      err_total++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chkn
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic chk_regs();
    rd(ADDR_CTRL_A, v);
    chk8("ctrl_a", sa, v);
    rd(ADDR_CTRL_B, v);
    chk8("ctrl_b", sb, v);
    chk1("repeater", sa[6], repeater_mode);
    chk1("tx_fc", sa[5], tx_flow_ctrl_en);
    chk1("rx_fc", sa[4], rx_flow_ctrl_en);
    chk1("backoff", sa[0], aggressive_backoff);
    chk1("carrier_bp", sb[5], carrier_sense_backpressure);
    chk1("mirror", sb[7], port_mirror_allowed);
    chk8("prio_bufs", sb[0] ? 8'h30 : 8'h00, {2'h0, prio_reserved_buffers});
  endtask : chk_regs

  task automatic set_regs(input logic [7:0] a, input logic [7:0] b);
    wr(ADDR_CTRL_A, a);
    sa = a;
    wr(ADDR_CTRL_B, b);
    sb = b;
    chk_regs();
  endtask : set_regs

  task automatic do_reset(input logic ms, input logic rx);
    @(posedge clk);
    arst_n <= 1'b0;
    switch_port_mode_strap <= ms;
    switch_port_rx_bit0_strap <= rx;
    repeat (5) @(posedge clk);
    #1 chk1("fc_in_reset", 1'b1, tx_flow_ctrl_en & rx_flow_ctrl_en);
    chk1("verdict_in_reset", 1'b0, v_valid);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    sa = 8'h34 | {7'h0, ms};
    sb = 8'hf1 | {4'h0, ms, 1'b0, rx, 1'b0};
    chk_regs();
    $display("test reset straps %b%b done", ms, rx);
  endtask : do_reset

  // ----------------------------------------------------------------
  // frames
  // ----------------------------------------------------------------
  function automatic logic [6:0] expect_verdict(input logic [10:0] len, input logic tg, input logic er,
    input logic [15:0] lt, input logic [47:0] da, input logic cr, input logic ku, input logic sn);
    logic [10:0] lim;
    logic [10:0] pay;
    logic de, ds, dl, dv, st;
    lim = sb[2] ? 11'h77c : (sb[1] ? (tg ? 11'h5f2 : 11'h5ee) : 11'h600);
    pay = len - (tg ? 11'h016 : 11'h012);
    de = er && !(sa[7] && sn);
    ds = len > lim;
    dl = sa[3] && lt < 16'h05dc && lt != {5'h0, pay} && !(pay == 11'h02e && lt < 16'h002e);
    dv = cr && (sb[7] || !ku);
    st = (da == 48'hffffffffffff) || (!sb[6] && da[40]);
    return {1'b1, !(de | ds | dl | dv), de, ds, dl, dv, st};
  endfunction : expect_verdict

  task automatic send_frame();
    logic [10:0] len;
    logic [15:0] lt;
    logic [47:0] da;
    logic [6:0] exp;
    logic [4:0] cc;
    logic tg, er, cr, ku, sn, sc;
    tg = 1'($urandom);
    er = 1'($urandom);
    cr = 1'($urandom);
    ku = 1'($urandom);
    sn = 1'($urandom);
    sc = 1'($urandom);
    cc = 5'($urandom);
    len = ($urandom % 3 == 0) ? corner[$urandom % 10] : 11'(64 + $urandom % 1900);
    lt = ($urandom % 2 == 0) ? 16'(len - (tg ? 11'h016 : 11'h012)) : 16'($urandom % 1600);
    da = 48'({$urandom, $urandom});
    if ($urandom % 3 == 0) da = 48'hffffffffffff;
    exp = expect_verdict(len, tg, er, lt, da, cr, ku, sn);
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_len <= len;
    frame_tagged <= tg;
    frame_errored <= er;
    frame_len_type <= lt;
    frame_da <= da;
    frame_crosses_vlan <= cr;
    frame_known_unicast <= ku;
    sniffer_active <= sn;
    collision_count <= cc;
    shared_dest_contention <= sc;
    @(posedge clk);
    frame_valid <= 1'b0;
    #1 chk8("verdict", {1'b0, exp}, {1'b0, v_valid, v_accept, v_err, v_size, v_len, v_vlan, v_storm});
    chk1("excess_coll", cc >= 5'h10 && !sb[3], excess_collision_drop);
    chk1("drop_non_fc", sc && sb[4], drop_non_fc_source);
    chk1("pause_fc", sc && !sb[4], pause_fc_source);
  endtask : send_frame

  task automatic wait_age(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (age_pulse !== 1'b1 && k < 300);
  endtask : wait_age

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hb4f1));
    do_reset(1'b1, 1'b0);
    @(posedge clk);
    switch_port_mode_strap <= 1'b0;
    switch_port_rx_bit0_strap <= 1'b1;
    chk_regs();
    wr(8'h08, 8'hff);
    wr(8'h0d, 8'h00);
    chk_regs();
    rd(8'h0c, v);
    chk8("unmapped_rd", 8'h00, v);
    $display("test straps and unmapped done");
    repeat (16) set_regs(8'($urandom), 8'($urandom));
    $display("test register access done");
    repeat (12) begin
      set_regs(8'($urandom), 8'($urandom));
      repeat (20) send_frame();
    end
    $display("test frames done");
    set_regs(8'h34, sb);
    wait_age(n);
    wait_age(n);
    chkn("normal_period", 40, n);
    wr(ADDR_CTRL_A, 8'h36);
    @(posedge clk);
    #1 chk1("fast_active", 1'b1, fast_age_active);
    wait_age(n);
    chkn("fast_period_ok", 1, int'(n <= 16));
    wait_age(n);
    chkn("after_fast", 40, n);
    chk1("fast_done", 1'b0, fast_age_active);
    @(posedge clk);
    link_loss_age <= 1'b1;
    @(posedge clk);
    link_loss_age <= 1'b0;
    wait_age(n);
    chkn("link_fast_ok", 1, int'(n <= 17));
    wait_age(n);
    chkn("after_link", 40, n);
    wr(ADDR_CTRL_A, 8'h30);
    wait_age(n);
    chkn("aging_off", 300, n);
    $display("test aging done");
    do_reset(1'b0, 1'b1);
    conclude();
  end

  initial begin
    #80000;
    err_total++;
    conclude();
  end
endmodule : switch_global_control_regs_test
